/* File: core/spm_cfg.svh */
// Constants for the shared pin function multiplexer.
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH

// Register bus geometry.
`define SPM_ADDR_W 4
`define SPM_DATA_W 8

// Register offsets.
`define SPM_OFS_DATA 4'h0
`define SPM_OFS_DIR 4'h1
`define SPM_OFS_PULL 4'h2
`define SPM_OFS_IRQC 4'h3
`define SPM_OFS_IRQS 4'h4
`define SPM_OFS_OWN1 4'h5
`define SPM_OFS_OWN2 4'h6

// Field positions of the interrupt pin control register.
`define SPM_IRQC_EN 0
`define SPM_IRQC_RISE 1
`define SPM_IRQC_PE 2

// Field positions of the interrupt pin status register.
`define SPM_IRQS_SENSE 0
`define SPM_IRQS_RAW 1

// Reset values.
`define SPM_RST_BIT 1'b0
`define SPM_RST_IRQC 3'h0

// Pins that carry the keyboard interrupt module as first alternate.
`define SPM_KB_MASK 8'h8d

`endif

/* File: core/spm_irq_pin.sv */
// Enable and pull selection for the external interrupt pin.
`timescale 1ns/1ns
module spm_irq_pin (
  // Control.
  input wire spm_pkg::spm_irqc_type ctl,
  // Synchronised pin level.
  input wire logic level,
  // Results.
  output logic pu,
  output logic pd,
  output logic sense,
  output logic branch
);

  // A disabled pin gives no source, no pull and no branch level.
  always_comb begin
    sense = ctl.en & level;
    branch = ctl.en & level;
    pu = ctl.en & ctl.pe & ~ctl.rise;
    pd = ctl.en & ctl.pe & ctl.rise;
  end

endmodule

/* File: core/spm_pin_cell.sv */
// Priority and pad control for one shared pin.
`timescale 1ns/1ns
module spm_pin_cell #(
  parameter bit KB_PIN = 1'b0
) (
  // Port registers for this pin.
  input wire logic dir,
  input wire logic data,
  input wire logic pull_en,
  // Peripheral claims.
  input wire spm_pkg::spm_alt_type alt1,
  input wire spm_pkg::spm_alt_type alt2,
  input wire logic kb_rise,
  // Result.
  output spm_pkg::spm_drive_type drive,
  output spm_pkg::spm_owner_type owner
);

  // Pick the owner and derive the pad controls from it.
  always_comb begin
    owner = spm_pkg::SPM_OWN_PORT;
    drive.oe = dir;
    drive.out = data;
    if (alt2.en) begin
      owner = spm_pkg::SPM_OWN_ALT2;
      drive.oe = alt2.oe;
      drive.out = alt2.out;
    end else if (alt1.en) begin
      owner = spm_pkg::SPM_OWN_ALT1;
      drive.oe = alt1.oe;
      drive.out = alt1.out;
    end
    // Pull only acts while the buffer is off.
    drive.pu = pull_en & ~drive.oe;
    drive.pd = 1'b0;
    if (KB_PIN && owner == spm_pkg::SPM_OWN_ALT1 && kb_rise) begin
      drive.pd = drive.pu;
      drive.pu = 1'b0;
    end
  end

endmodule

/* File: core/spm_pkg.sv */
// Types shared by the shared pin function multiplexer.
package spm_pkg;

  // One peripheral's claim on a pin.
  typedef struct packed {
    logic en;
    logic oe;
    logic out;
  } spm_alt_type;

  // What the pad sees from the logic.
  typedef struct packed {
    logic oe;
    logic out;
    logic pu;
    logic pd;
  } spm_drive_type;

  // Who controls a pin.
  typedef enum logic [1:0] {
    SPM_OWN_PORT,
    SPM_OWN_ALT1,
    SPM_OWN_ALT2
  } spm_owner_type;

  // Interrupt pin control bits.
  typedef struct packed {
    logic pe;
    logic rise;
    logic en;
  } spm_irqc_type;

endpackage

/* File: core/spm_top.sv */
// Shared pin function multiplexer with port registers and interrupt pin.
`timescale 1ns/1ns
`include "spm_cfg.svh"
module spm_top #(
  parameter int N = 8,
  parameter logic [7:0] KB_MASK = `SPM_KB_MASK
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // Register port.
  input wire logic [`SPM_ADDR_W-1:0] reg_addr,
  input wire logic [`SPM_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`SPM_DATA_W-1:0] reg_rdata,
  // First alternate function claims, one per pin.
  input wire spm_pkg::spm_alt_type [N-1:0] alt1,
  // Second alternate function claims, one per pin.
  input wire spm_pkg::spm_alt_type [N-1:0] alt2,
  // Keyboard module rising or high sensitivity, one per pin.
  input wire logic [N-1:0] kb_rise,
  // Shared pads.
  input wire logic [N-1:0] pin_in,
  output logic [N-1:0] pin_out,
  output logic [N-1:0] pin_oe,
  output logic [N-1:0] pin_pu,
  output logic [N-1:0] pin_pd,
  // Synchronised pad levels for the peripherals.
  output logic [N-1:0] periph_in,
  // External interrupt pad.
  input wire logic irq_pin_in,
  output logic irq_pin_pu,
  output logic irq_pin_pd,
  // Interrupt pin to request logic and to the branch instructions.
  output logic irq_sense,
  output logic branch_if_pin_level
);

  // Every register of the block.
  typedef struct packed {
    logic [N-1:0] sync1;
    logic [N-1:0] sync2;
    logic irq_sync1;
    logic irq_sync2;
    logic [N-1:0] data;
    logic [N-1:0] dir;
    logic [N-1:0] pull;
    spm_pkg::spm_irqc_type irqc;
    logic [`SPM_DATA_W-1:0] rdata;
    logic [N-1:0] pin_out;
    logic [N-1:0] pin_oe;
    logic [N-1:0] pin_pu;
    logic [N-1:0] pin_pd;
    logic [N-1:0] own1;
    logic [N-1:0] own2;
    logic irq_pu;
    logic irq_pd;
    logic irq_sense;
    logic branch;
  } spm_state_type;

  spm_state_type state_ff;
  spm_state_type nxt_state;

  // Combinational results of the pin cells and interrupt pin.
  spm_pkg::spm_drive_type [N-1:0] drive;
  spm_pkg::spm_owner_type [N-1:0] owner;
  logic irq_pu_c;
  logic irq_pd_c;
  logic irq_sense_c;
  logic irq_branch_c;

  // Decoded register accesses.
  logic wr_data;
  logic wr_dir;
  logic wr_pull;
  logic wr_irqc;

  // Readback values widened to the data bus.
  logic [`SPM_DATA_W-1:0] rb_data;
  logic [`SPM_DATA_W-1:0] rb_dir;
  logic [`SPM_DATA_W-1:0] rb_pull;
  logic [`SPM_DATA_W-1:0] rb_irqc;
  logic [`SPM_DATA_W-1:0] rb_irqs;
  logic [`SPM_DATA_W-1:0] rb_own1;
  logic [`SPM_DATA_W-1:0] rb_own2;

  // One priority cell per shared pin.
  generate
    for (genvar i = 0; i < N; i++) begin : g_pin
      spm_pin_cell #(
        .KB_PIN(KB_MASK[i])
      ) u_cell (
        .dir(state_ff.dir[i]),
        .data(state_ff.data[i]),
        .pull_en(state_ff.pull[i]),
        .alt1(alt1[i]),
        .alt2(alt2[i]),
        .kb_rise(kb_rise[i]),
        .drive(drive[i]),
        .owner(owner[i])
      );
    end
  endgenerate

  // External interrupt pin control.
  spm_irq_pin u_irq (
    .ctl(state_ff.irqc),
    .level(state_ff.irq_sync2),
    .pu(irq_pu_c),
    .pd(irq_pd_c),
    .sense(irq_sense_c),
    .branch(irq_branch_c)
  );

  // Write decode; writes to unmapped or read-only offsets are dropped.
  always_comb begin
    wr_data = reg_wr && (reg_addr == `SPM_OFS_DATA);
    wr_dir = reg_wr && (reg_addr == `SPM_OFS_DIR);
    wr_pull = reg_wr && (reg_addr == `SPM_OFS_PULL);
    wr_irqc = reg_wr && (reg_addr == `SPM_OFS_IRQC);
  end

  // Readback for each register, with bits above the pins reading zero.
  always_comb begin
    rb_data = '0;
    rb_dir = '0;
    rb_pull = '0;
    rb_irqc = '0;
    rb_irqs = '0;
    rb_own1 = '0;
    rb_own2 = '0;
    for (int i = 0; i < N; i++) begin
      // Outputs read the latch, inputs read the pad.
      rb_data[i] = state_ff.dir[i] ? state_ff.data[i]
                                   : state_ff.sync2[i];
      rb_dir[i] = state_ff.dir[i];
      rb_pull[i] = state_ff.pull[i];
      rb_own1[i] = state_ff.own1[i];
      rb_own2[i] = state_ff.own2[i];
    end
    rb_irqc[`SPM_IRQC_EN] = state_ff.irqc.en;
    rb_irqc[`SPM_IRQC_RISE] = state_ff.irqc.rise;
    rb_irqc[`SPM_IRQC_PE] = state_ff.irqc.pe;
    rb_irqs[`SPM_IRQS_SENSE] = state_ff.irq_sense;
    rb_irqs[`SPM_IRQS_RAW] = state_ff.irq_sync2;
  end

  // Next value of every register.
  always_comb begin
    nxt_state = state_ff;

    // Two-stage synchronisers on every pad input.
    nxt_state.sync1 = pin_in;
    nxt_state.sync2 = state_ff.sync1;
    nxt_state.irq_sync1 = irq_pin_in;
    nxt_state.irq_sync2 = state_ff.irq_sync1;

    // Software writes to the port and interrupt pin registers.
    if (wr_data) begin
      nxt_state.data = reg_wdata[N-1:0];
    end
    if (wr_dir) begin
      nxt_state.dir = reg_wdata[N-1:0];
    end
    if (wr_pull) begin
      nxt_state.pull = reg_wdata[N-1:0];
    end
    if (wr_irqc) begin
      nxt_state.irqc.en = reg_wdata[`SPM_IRQC_EN];
      nxt_state.irqc.rise = reg_wdata[`SPM_IRQC_RISE];
      nxt_state.irqc.pe = reg_wdata[`SPM_IRQC_PE];
    end

    // Read data stand only in the cycle after the read strobe.
    nxt_state.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        `SPM_OFS_DATA: begin
          nxt_state.rdata = rb_data;
        end
        `SPM_OFS_DIR: begin
          nxt_state.rdata = rb_dir;
        end
        `SPM_OFS_PULL: begin
          nxt_state.rdata = rb_pull;
        end
        `SPM_OFS_IRQC: begin
          nxt_state.rdata = rb_irqc;
        end
        `SPM_OFS_IRQS: begin
          nxt_state.rdata = rb_irqs;
        end
        `SPM_OFS_OWN1: begin
          nxt_state.rdata = rb_own1;
        end
        `SPM_OFS_OWN2: begin
          nxt_state.rdata = rb_own2;
        end
        default: begin
          nxt_state.rdata = '0;
        end
      endcase
    end

    // Register the pad controls chosen by the cells.
    for (int i = 0; i < N; i++) begin
      nxt_state.pin_oe[i] = drive[i].oe;
      nxt_state.pin_out[i] = drive[i].out;
      nxt_state.pin_pu[i] = drive[i].pu;
      nxt_state.pin_pd[i] = drive[i].pd;
      nxt_state.own1[i] = (owner[i] == spm_pkg::SPM_OWN_ALT1);
      nxt_state.own2[i] = (owner[i] == spm_pkg::SPM_OWN_ALT2);
    end

    // Register the interrupt pin results.
    nxt_state.irq_pu = irq_pu_c;
    nxt_state.irq_pd = irq_pd_c;
    nxt_state.irq_sense = irq_sense_c;
    nxt_state.branch = irq_branch_c;
  end

  // State register; reset leaves every pin an undriven input, no pull.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff.sync1 <= {N{`SPM_RST_BIT}};
      state_ff.sync2 <= {N{`SPM_RST_BIT}};
      state_ff.irq_sync1 <= `SPM_RST_BIT;
      state_ff.irq_sync2 <= `SPM_RST_BIT;
      state_ff.data <= {N{`SPM_RST_BIT}};
      state_ff.dir <= {N{`SPM_RST_BIT}};
      state_ff.pull <= {N{`SPM_RST_BIT}};
      state_ff.irqc <= `SPM_RST_IRQC;
      state_ff.rdata <= '0;
      state_ff.pin_out <= {N{`SPM_RST_BIT}};
      state_ff.pin_oe <= {N{`SPM_RST_BIT}};
      state_ff.pin_pu <= {N{`SPM_RST_BIT}};
      state_ff.pin_pd <= {N{`SPM_RST_BIT}};
      state_ff.own1 <= {N{`SPM_RST_BIT}};
      state_ff.own2 <= {N{`SPM_RST_BIT}};
      state_ff.irq_pu <= `SPM_RST_BIT;
      state_ff.irq_pd <= `SPM_RST_BIT;
      state_ff.irq_sense <= `SPM_RST_BIT;
      state_ff.branch <= `SPM_RST_BIT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Register port answer.
  assign reg_rdata = state_ff.rdata;

  // Pad controls, all straight from the state register.
  assign pin_out = state_ff.pin_out;
  assign pin_oe = state_ff.pin_oe;
  assign pin_pu = state_ff.pin_pu;
  assign pin_pd = state_ff.pin_pd;

  // Every peripheral sees the pad whether it owns it or not, so a
  // higher function taking over can toggle a lower module's input.
  assign periph_in = state_ff.sync2;

  // Interrupt pad and its consumers.
  assign irq_pin_pu = state_ff.irq_pu;
  assign irq_pin_pd = state_ff.irq_pd;
  assign irq_sense = state_ff.irq_sense;
  assign branch_if_pin_level = state_ff.branch;

endmodule

/* File: tb/spm_pad_model.sv */
// Pads and board: resolves each pin level from drive, pulls and board.
`timescale 1ns/1ns
module spm_pad_model #(
  parameter int N = 8
) (
  // From the multiplexer.
  input wire logic [N-1:0] pin_out,
  input wire logic [N-1:0] pin_oe,
  input wire logic [N-1:0] pin_pu,
  input wire logic [N-1:0] pin_pd,
  input wire logic irq_pu,
  input wire logic irq_pd,
  // Board levels seen when nothing drives or pulls.
  input wire logic [N-1:0] ext,
  input wire logic ext_irq,
  // Back to the multiplexer.
  output logic [N-1:0] pin_in,
  output logic irq_in
);
  // Drive wins, then pullup, then pulldown, then the board.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & (pin_pu | (~pin_pd & ext)));
  assign irq_in = irq_pu | (~irq_pd & ext_irq);
endmodule

/* File: tb/spm_top_sva.sv */
// Concurrent checks on the ports of the shared pin multiplexer.
`timescale 1ns/1ns
module spm_top_sva #(
  parameter int N = 8,
  parameter logic [7:0] KB_MASK = 8'h8d
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // Claims.
  input wire spm_pkg::spm_alt_type [N-1:0] alt1,
  input wire spm_pkg::spm_alt_type [N-1:0] alt2,
  input wire logic [N-1:0] kb_rise,
  // Pads.
  input wire logic [N-1:0] pin_out,
  input wire logic [N-1:0] pin_oe,
  input wire logic [N-1:0] pin_pu,
  input wire logic [N-1:0] pin_pd,
  // Interrupt pin.
  input wire logic irq_pin_pu,
  input wire logic irq_pin_pd,
  input wire logic irq_sense,
  input wire logic branch_if_pin_level
);
  // All checks share the one clock and reset.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_own2;
    $past(nrst) && $past(alt2[0].en) |-> pin_oe[0] == $past(alt2[0].oe)
      && pin_out[0] == $past(alt2[0].out);
  endproperty
  a_own2: assert property (p_own2) else $error("second claim lost");
  property p_own1;
    $past(nrst) && $past(alt1[0].en && !alt2[0].en)
      |-> pin_oe[0] == $past(alt1[0].oe);
  endproperty
  a_own1: assert property (p_own1) else $error("first claim lost");
  property p_pullx;
    (pin_oe & (pin_pu | pin_pd)) == '0;
  endproperty
  a_pullx: assert property (p_pullx) else $error("pull on output");
  property p_kbpd;
    $past(nrst) && $past(alt1[0].en && !alt2[0].en && kb_rise[0])
      |-> !pin_pu[0];
  endproperty
  a_kbpd: assert property (p_kbpd) else $error("keyboard pullup");
  property p_nonkb;
    (pin_pd & ~KB_MASK[N-1:0]) == '0;
  endproperty
  a_nonkb: assert property (p_nonkb) else $error("pulldown on port");
  property p_reset;
    !$past(nrst) |-> pin_oe == '0 && pin_pu == '0 && pin_pd == '0;
  endproperty
  a_reset: assert property (p_reset) else $error("pins after reset");
  property p_sense;
    irq_sense == branch_if_pin_level;
  endproperty
  a_sense: assert property (p_sense) else $error("irq paths differ");
  property p_irqpull;
    !(irq_pin_pu && irq_pin_pd);
  endproperty
  a_irqpull: assert property (p_irqpull) else $error("both pulls");
  // Main scenarios reached.
  c_own2: cover property (alt2[0].en ##1 pin_oe[0]);
  c_kbpd: cover property (pin_pd[0]);
  c_irqpd: cover property (irq_pin_pd);
endmodule
bind spm_top spm_top_sva #(.N(N), .KB_MASK(KB_MASK)) spm_top_sva_i (
  .sys_clk(sys_clk), .nrst(nrst), .alt1(alt1), .alt2(alt2),
  .kb_rise(kb_rise), .pin_out(pin_out), .pin_oe(pin_oe),
  .pin_pu(pin_pu), .pin_pd(pin_pd), .irq_pin_pu(irq_pin_pu),
  .irq_pin_pd(irq_pin_pd), .irq_sense(irq_sense),
  .branch_if_pin_level(branch_if_pin_level));

/* File: tb/spm_top_tb.sv */
// Self-checking bench for the shared pin multiplexer.
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module spm_top_tb;
  logic sys_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, ext_irq = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, kb = 8'h00, ext = 8'h00;
  logic [7:0] p_in, p_out, p_oe, p_pu, p_pd, p_per;
  logic i_in, i_pu, i_pd, i_sn, i_br;
  spm_pkg::spm_alt_type [7:0] a1 = '0, a2 = '0;
  int n_errors = 0, n_checks = 0, cyc = 0;
  spm_top spm_top_i (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .alt1(a1), .alt2(a2), .kb_rise(kb),
    .pin_in(p_in), .pin_out(p_out), .pin_oe(p_oe), .pin_pu(p_pu),
    .pin_pd(p_pd), .periph_in(p_per), .irq_pin_in(i_in),
    .irq_pin_pu(i_pu), .irq_pin_pd(i_pd), .irq_sense(i_sn),
    .branch_if_pin_level(i_br));
  spm_pad_model spm_pad_model_i (.pin_out(p_out), .pin_oe(p_oe),
    .pin_pu(p_pu), .pin_pd(p_pd), .irq_pu(i_pu), .irq_pd(i_pd),
    .ext(ext), .ext_irq(ext_irq), .pin_in(p_in), .irq_in(i_in));
  // Clock of 20 ns and a cycle ceiling against hangs.
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task report_and_stop;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e, input string n);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    `CHK(n, e, reg_rdata)
  endtask
  // A write reaches the pads one edge late and the interrupt level four
  // edges late, so six edges cover every path back through the pads.
  task st;
    repeat (6) @(negedge sys_clk);
  endtask
  // Main sequence.
  initial begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk);
    `CHK("oe", 8'h00, p_oe)
    `CHK("pullup", 8'h00, p_pu)
    rd(4'h1, 8'h00, "dir");
    $display("reset test done");
    wr(4'h1, 8'hff);
    wr(4'h0, 8'ha5);
    wr(4'h2, 8'hff);
    st();
    `CHK("oe", 8'hff, p_oe)
    `CHK("out", 8'ha5, p_out)
    `CHK("pullup", 8'h00, p_pu)
    rd(4'h0, 8'ha5, "data");
    wr(4'h1, 8'h00);
    st();
    `CHK("pullup", 8'hff, p_pu)
    `CHK("pulldown", 8'h00, p_pd)
    rd(4'h0, 8'hff, "pad");
    $display("port test done");
    @(posedge sys_clk);
    a1 <= {8{3'b111}};
    a2 <= {{4{3'b000}}, {4{3'b110}}};
    st();
    `CHK("oe", 8'hff, p_oe)
    `CHK("out", 8'hf0, p_out)
    `CHK("pullup", 8'h00, p_pu)
    `CHK("periph", 8'hf0, p_per)
    rd(4'h0, 8'hf0, "pad");
    rd(4'h5, 8'hf0, "own1");
    rd(4'h6, 8'h0f, "own2");
    wr(4'h5, 8'h00);
    rd(4'h5, 8'hf0, "own1 ro");
    rd(4'hf, 8'h00, "unmapped");
    wr(4'h1, 8'hff);
    rd(4'h0, 8'ha5, "latch");
    $display("priority test done");
    wr(4'h1, 8'h00);
    a2 <= '0;
    a1 <= '0;
    @(posedge sys_clk);
    a1 <= {8{3'b100}};
    kb <= 8'hff;
    // Spurious edges from the new claim die out before anything is read.
    st();
    `CHK("pulldown", 8'h8d, p_pd)
    `CHK("pullup", 8'h72, p_pu)
    $display("keyboard test done");
    @(posedge sys_clk);
    a1 <= '0;
    kb <= 8'h00;
    wr(4'h3, 8'h05);
    st();
    `CHK("irq pulls", 2'b10, {i_pu, i_pd})
    `CHK("sense", 1'b1, i_sn)
    `CHK("branch", 1'b1, i_br)
    rd(4'h4, 8'h03, "status");
    wr(4'h3, 8'h07);
    st();
    `CHK("irq pulls", 2'b01, {i_pu, i_pd})
    `CHK("sense", 1'b0, i_sn)
    wr(4'h3, 8'h00);
    ext_irq <= 1'b1;
    st();
    `CHK("irq pulls", 2'b00, {i_pu, i_pd})
    `CHK("sense", 1'b0, i_sn)
    `CHK("branch", 1'b0, i_br)
    rd(4'h4, 8'h02, "status off");
    $display("irq test done");
    wr(4'h1, 8'hff);
    wr(4'h3, 8'h05);
    st();
    `CHK("oe", 8'hff, p_oe)
    `CHK("irq pulls", 2'b10, {i_pu, i_pd})
    // A second reset in mid-run must return every pin to its idle state.
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk);
    `CHK("oe", 8'h00, p_oe)
    `CHK("pullup", 8'h00, p_pu)
    `CHK("pulldown", 8'h00, p_pd)
    `CHK("irq pulls", 2'b00, {i_pu, i_pd})
    rd(4'h2, 8'h00, "pull");
    rd(4'h1, 8'h00, "dir");
    $display("second reset test done");
    report_and_stop();
  end
endmodule
